//--- design/gpio_port_cfg.svh
// Register indices, field positions, reset values for the GPIO port block.
// Assumes byte address = 4 * index on an AHB-Lite bus with 32-bit data.
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH

// Register indices (byte address is four times the index)
`define IDX_PORT_ZERO_DATA     8'hd0
`define IDX_PORT_ONE_DATA      8'hd1
`define IDX_PORT_FIVE_DATA     8'hd5
`define IDX_PORT_ZERO_PULLUP   8'he0
`define IDX_PORT_ONE_PULLUP    8'he1
`define IDX_PORT_FIVE_PULLUP   8'he5
`define IDX_OPEN_DRAIN_CONTROL 8'he9
`define IDX_PORT_ZERO_DIR      8'hb8
`define IDX_PORT_ONE_DIR       8'hc1
`define IDX_PORT_FIVE_DIR      8'hc5
`define IDX_PORT_ZERO_SET      8'hf0
`define IDX_PORT_ONE_SET       8'hf1
`define IDX_PORT_FIVE_SET      8'hf5
`define IDX_PORT_ZERO_CLR      8'hf8
`define IDX_PORT_ONE_CLR       8'hf9
`define IDX_PORT_FIVE_CLR      8'hfd

// Pad vector layout: bit 0 port zero, bits 8:1 port one, bits 15:9 port five
`define PAD_COUNT              16
`define PAD_PORT_FIVE_LSB      9
`define PAD_INPUT_ONLY         15
`define OD_FIELD_LSB           2
`define OD_FIELD_MSB           6

// Reset values
`define RST_LATCH              16'h0000
`define RST_DIR                16'h8000
`define RST_PULLUP             16'h8000
`define RST_OPEN_DRAIN         5'h00

`endif

//--- design/gpio_port_pkg.sv
// Types shared by the GPIO port block and its bench.
// Assumes the pad vector layout from gpio_port_cfg.svh.
package gpio_port_pkg;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] pu;
  } pad_drive_s;

  typedef enum logic {
    BUS_IDLE,
    BUS_DATA
  } bus_state_e;

endpackage

//--- design/gpio_pullup_opendrain_port.sv
// GPIO logic for an 8-bit, a 1-bit and a 7-bit port with pull-up and open-drain control.
// Assumes a single AHB-Lite master, pads resolved outside from out/oe/pu, one 10 MHz clock.
//
// Function
// - A 1 written to a pull-up enable bit connects the pin's pull-up, a 0 disconnects it; write-only.
// - The input-only pin six of the seven-bit port keeps its pull-up on; its enable bit stays 1.
// - A port data read returns the current synchronised pin levels.
// - A whole-byte data write latches the byte and drives it on every output-mode pin.
// - Single-bit set and clear change only the addressed latch bits.
// - Bit 6 of the seven-bit port data is read-only and reads 1 when the reset-pin option is set.
// - Only pins 0 to 4 of the seven-bit port have open-drain capability.
// - In open-drain mode a 0 sinks the pin low and a 1 releases it.
// - Open-drain control bits 2 to 6 map to seven-bit-port pins 0 to 4; 1 enables.
// - Clearing open-drain returns the pin to its push-pull input or output behaviour.
// - A direction bit of 0 selects input, 1 output; the driver is on only for outputs.
// - Pin six of the seven-bit port never enables an output driver.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"

module gpio_pullup_opendrain_port (
  input  logic                      i_clk,            // 10 MHz clock
  input  logic                      i_rst,            // Sync reset, active high
  input  logic                      i_hsel,           // AHB slave select
  input  logic [31:0]               i_haddr,          // AHB address
  input  logic [1:0]                i_htrans,         // AHB transfer type
  input  logic                      i_hwrite,         // AHB write
  input  logic [2:0]                i_hsize,          // AHB size (word only)
  input  logic [31:0]               i_hwdata,         // AHB write data
  input  logic                      i_hready,         // AHB bus ready
  output logic [31:0]               o_hrdata,         // AHB read data
  output logic                      o_hreadyout,      // AHB slave ready
  output logic                      o_hresp,          // AHB response, always OKAY
  input  logic [15:0]               i_pad_in,         // Pad levels, async
  input  logic                      i_ext_reset_opt,  // Reset-pin option strap, async
  output gpio_port_pkg::pad_drive_s o_pad             // Pad drive: out, enable, pull-up
);

  // Three-stage synchronisers for pads and strap
  logic [16:0] sync1;
  logic [16:0] sync2;
  logic [16:0] sync3;
  logic [16:0] lvl;
  logic [16:0] next_lvl;

  genvar g;
  generate
    for (g = 0; g < 17; g = g + 1)
    begin : g_sync
      always_comb
      begin
        next_lvl[g] = (sync2[g] == sync3[g]) ? sync3[g] : lvl[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clk)
  begin
    sync1 <= {i_ext_reset_opt, i_pad_in};
    sync2 <= sync1;
    sync3 <= sync2;
    if (i_rst)
      lvl <= 17'h0_0000;
    else
      lvl <= next_lvl;
  end

  wire ext_opt = lvl[16];

  // Bus slave: one wait state per transfer
  gpio_port_pkg::bus_state_e state;
  gpio_port_pkg::bus_state_e next_state;
  logic [7:0]  idx;
  logic [7:0]  next_idx;
  logic        wr;
  logic        next_wr;
  logic        ok;
  logic        next_ok;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;

  wire take = i_hsel && i_htrans[1] && i_hready;
  wire pend = (state == gpio_port_pkg::BUS_DATA);
  wire wr_fire = pend && wr && ok;

  // Port registers
  logic [15:0] lat;
  logic [15:0] dir;
  logic [15:0] pu;
  logic [4:0]  od;
  logic [15:0] next_lat;
  logic [15:0] next_dir;
  logic [15:0] next_pu;
  logic [4:0]  next_od;

  // Spread a port byte over the pad vector
  function automatic logic [15:0] spread(input logic [7:0] idx_f, input logic [7:0] d);
    logic [15:0] m;
    m = 16'h0000;
    case (idx_f)
      `IDX_PORT_ZERO_DATA, `IDX_PORT_ZERO_SET, `IDX_PORT_ZERO_CLR, `IDX_PORT_ZERO_PULLUP, `IDX_PORT_ZERO_DIR:
        m[0] = d[0];
      `IDX_PORT_ONE_DATA, `IDX_PORT_ONE_SET, `IDX_PORT_ONE_CLR, `IDX_PORT_ONE_PULLUP, `IDX_PORT_ONE_DIR:
        m[8:1] = d;
      `IDX_PORT_FIVE_DATA, `IDX_PORT_FIVE_SET, `IDX_PORT_FIVE_CLR, `IDX_PORT_FIVE_PULLUP, `IDX_PORT_FIVE_DIR:
        m[14:9] = d[5:0];
      default:
        m = 16'h0000;
    endcase
    return m;
  endfunction

  logic [15:0] wmask;
  logic [15:0] wbits;

  always_comb
  begin
    next_state     = gpio_port_pkg::BUS_IDLE;
    next_idx       = idx;
    next_wr        = wr;
    next_ok        = ok;
    next_hreadyout = 1'b1;
    next_hrdata    = o_hrdata;
    case (state)
      gpio_port_pkg::BUS_IDLE:
      begin
        if (take)
        begin
          next_state     = gpio_port_pkg::BUS_DATA;
          next_idx       = i_haddr[9:2];
          next_wr        = i_hwrite;
          next_ok        = (i_haddr[31:10] == 22'h00_0000) && (i_haddr[1:0] == 2'b00);
          next_hreadyout = 1'b0;
        end
      end
      gpio_port_pkg::BUS_DATA:
      begin
        next_hrdata = 32'h0000_0000;
        if (!wr && ok)
        begin
          case (idx)
            `IDX_PORT_ZERO_DATA: next_hrdata[0]   = lvl[0];
            `IDX_PORT_ONE_DATA:  next_hrdata[7:0] = lvl[8:1];
            `IDX_PORT_FIVE_DATA: next_hrdata[6:0] = {ext_opt | lvl[15], lvl[14:9]};
            `IDX_PORT_ZERO_DIR:  next_hrdata[0]   = dir[0];
            `IDX_PORT_ONE_DIR:   next_hrdata[7:0] = dir[8:1];
            `IDX_PORT_FIVE_DIR:  next_hrdata[6:0] = dir[15:9];
            // Pull-up and open-drain registers are write-only and read 0
            default:             next_hrdata      = 32'h0000_0000;
          endcase
        end
      end
      default:
        next_state = gpio_port_pkg::BUS_IDLE;
    endcase
  end

  always_comb
  begin
    wmask    = spread(idx, 8'hff);
    wbits    = spread(idx, i_hwdata[7:0]);
    next_lat = lat;
    next_dir = dir;
    next_pu  = pu;
    next_od  = od;
    if (wr_fire)
    begin
      case (idx)
        `IDX_PORT_ZERO_DATA, `IDX_PORT_ONE_DATA, `IDX_PORT_FIVE_DATA:
          next_lat = (lat & ~wmask) | wbits;
        `IDX_PORT_ZERO_SET, `IDX_PORT_ONE_SET, `IDX_PORT_FIVE_SET:
          next_lat = lat | wbits;
        `IDX_PORT_ZERO_CLR, `IDX_PORT_ONE_CLR, `IDX_PORT_FIVE_CLR:
          next_lat = lat & ~wbits;
        `IDX_PORT_ZERO_PULLUP, `IDX_PORT_ONE_PULLUP, `IDX_PORT_FIVE_PULLUP:
          next_pu = (pu & ~wmask) | wbits;
        `IDX_PORT_ZERO_DIR, `IDX_PORT_ONE_DIR, `IDX_PORT_FIVE_DIR:
          next_dir = (dir & ~wmask) | wbits;
        `IDX_OPEN_DRAIN_CONTROL:
          next_od = i_hwdata[`OD_FIELD_MSB:`OD_FIELD_LSB];
        default:
          next_lat = lat;
      endcase
    end
    next_pu[`PAD_INPUT_ONLY]  = 1'b1;
    next_dir[`PAD_INPUT_ONLY] = 1'b1;
    next_lat[`PAD_INPUT_ONLY] = 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state       <= gpio_port_pkg::BUS_IDLE;
      idx         <= 8'h00;
      wr          <= 1'b0;
      ok          <= 1'b0;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      lat         <= `RST_LATCH;
      dir         <= `RST_DIR;
      pu          <= `RST_PULLUP;
      od          <= `RST_OPEN_DRAIN;
    end
    else
    begin
      state       <= next_state;
      idx         <= next_idx;
      wr          <= next_wr;
      ok          <= next_ok;
      o_hrdata    <= next_hrdata;
      o_hreadyout <= next_hreadyout;
      o_hresp     <= 1'b0;
      lat         <= next_lat;
      dir         <= next_dir;
      pu          <= next_pu;
      od          <= next_od;
    end
  end

  // Pad drive, one generate branch per pad
  gpio_port_pkg::pad_drive_s next_pad;

  generate
    for (g = 0; g < `PAD_COUNT; g = g + 1)
    begin : g_pad
      // Only pads 9..13 have an open-drain control bit
      // Index clamped so pads without a control bit never select outside od
      localparam int OD_SEL = (g >= `PAD_PORT_FIVE_LSB && g < `PAD_PORT_FIVE_LSB + 5) ? g - `PAD_PORT_FIVE_LSB : 0;
      wire od_on = (g >= `PAD_PORT_FIVE_LSB && g < `PAD_PORT_FIVE_LSB + 5) ? od[OD_SEL] : 1'b0;
      always_comb
      begin
        next_pad.pu[g] = pu[g];
        if (g == `PAD_INPUT_ONLY)
        begin
          next_pad.oe[g]  = 1'b0;
          next_pad.out[g] = 1'b0;
        end
        else if (od_on)
        begin
          // Driven low only; a 1 lets the external pull-up win
          next_pad.oe[g]  = dir[g] & ~lat[g];
          next_pad.out[g] = 1'b0;
        end
        else
        begin
          next_pad.oe[g]  = dir[g];
          next_pad.out[g] = lat[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_pad <= {16'h0000, 16'h0000, `RST_PULLUP};
    else
      o_pad <= next_pad;
  end

  // Assertions
  a_pullup_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_fire && idx == `IDX_PORT_ONE_PULLUP |-> ##2 o_pad.pu[8:1] == $past(i_hwdata[7:0], 2))
    else $error("pull-up write not reflected on pads");
  a_pullup_fixed: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_pad.pu[15])
    else $error("input-only pad pull-up bit not 1");
  a_read_pins: assert property (@(posedge i_clk) disable iff (i_rst)
    pend && !wr && ok && idx == `IDX_PORT_ONE_DATA |=> o_hrdata[7:0] == $past(lvl[8:1]) && o_hreadyout)
    else $error("port read does not return pin levels");
  a_byte_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_fire && idx == `IDX_PORT_ONE_DATA |=> lat[8:1] == $past(i_hwdata[7:0]))
    else $error("byte write not latched");
  a_bit_set_only: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_fire && idx == `IDX_PORT_ONE_SET |=> ((lat ^ $past(lat)) & ~{7'h00, $past(i_hwdata[7:0]), 1'b0}) == 16'h0000)
    else $error("bit set touched other pins");
  a_reset_opt_read: assert property (@(posedge i_clk) disable iff (i_rst)
    pend && !wr && ok && idx == `IDX_PORT_FIVE_DATA && ext_opt |=> o_hrdata[6])
    else $error("reset-option pin bit not read as 1");
  a_od_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_fire && idx == `IDX_OPEN_DRAIN_CONTROL |=> od == $past(i_hwdata[6:2]))
    else $error("open-drain control bits misplaced");
  a_od_release: assert property (@(posedge i_clk) disable iff (i_rst)
    od[0] && dir[9] |=> o_pad.oe[9] == !$past(lat[9]) && !o_pad.out[9])
    else $error("open-drain pad not sinking or releasing");
  a_push_pull: assert property (@(posedge i_clk) disable iff (i_rst)
    !od[0] |=> o_pad.oe[9] == $past(dir[9]) && o_pad.out[9] == $past(lat[9]))
    else $error("push-pull pad wrong");
  a_input_no_drive: assert property (@(posedge i_clk) disable iff (i_rst)
    !dir[1] |=> !o_pad.oe[1])
    else $error("input-mode pad driven");
  a_input_only: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 !o_pad.oe[15])
    else $error("input-only pad driven");
  a_no_od_else: assert property (@(posedge i_clk) disable iff (i_rst)
    dir[1] |=> o_pad.oe[1] && o_pad.out[1] == $past(lat[1]))
    else $error("open-drain behaviour on a pad without it");
  a_reset_clear: assert property (@(posedge i_clk)
    i_rst |=> lat == 16'h0000 && od == 5'h00 && pu == 16'h8000)
    else $error("reset did not clear latches");

  c_od_write:  cover property (@(posedge i_clk) disable iff (i_rst) wr_fire && idx == `IDX_OPEN_DRAIN_CONTROL);
  c_port_read: cover property (@(posedge i_clk) disable iff (i_rst) pend && !wr && idx == `IDX_PORT_FIVE_DATA);
  c_od_low:    cover property (@(posedge i_clk) disable iff (i_rst) od[0] && dir[9] && !lat[9]);
  c_bit_clear: cover property (@(posedge i_clk) disable iff (i_rst) wr_fire && idx == `IDX_PORT_ONE_CLR);

endmodule

//--- tb/board_model.sv
// Board side of the GPIO pads: external drivers, pull-up resistors, floating lines.
// Assumes the pad bit layout of the GPIO block and the bench clock.
`timescale 1ns/1ps
module board_model #(
  parameter logic [15:0] BOARD_PULLUP = 16'h3e00  // Resistors on the open-drain pins
) (
  input  wire logic                      i_clk,      // Bench clock
  input  wire gpio_port_pkg::pad_drive_s i_pad,      // Drive from the block
  input  wire logic [15:0]               i_ext_en,   // Board driver enables
  input  wire logic [15:0]               i_ext_val,  // Board driver levels
  output logic [15:0]                    o_level     // Resolved pin levels
);
  logic [15:0] float_pat = 16'h5555;

  // Floating pins toggle so that a stale level never passes for a match
  always @(posedge i_clk)
    float_pat <= ~float_pat;

  always_comb
    for (int i = 0; i < 16; i++)
      if (i_pad.oe[i])
        o_level[i] = i_pad.out[i];
      else if (i_ext_en[i])
        o_level[i] = i_ext_val[i];
      else if (i_pad.pu[i] | BOARD_PULLUP[i])
        o_level[i] = 1'b1;
      else
        o_level[i] = float_pat[i];
endmodule

//--- tb/gpio_pullup_opendrain_port_tb.sv
// Self-checking bench for the GPIO port block, driven as an AHB-Lite master.
// Assumes the board model on the pads and the register indices of the cfg header.
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"
module gpio_pullup_opendrain_port_tb;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      hsel = 1'b0;
  logic [31:0]               haddr = '0;
  logic [1:0]                htrans = 2'b00;
  logic                      hwrite = 1'b0;
  logic [2:0]                hsize = 3'b010;
  logic [31:0]               hwdata = '0;
  logic [31:0]               hrdata;
  logic                      hready;
  logic                      hresp;
  logic                      ext_opt = 1'b0;
  logic [15:0]               ext_en = '1;
  logic [15:0]               ext_val = '0;
  logic [15:0]               level;
  gpio_port_pkg::pad_drive_s pad;
  logic [31:0]               seed = 32'h0000_5792;
  int                        fails = 0;
  int                        comparisons = 0;
  logic [31:0]               v;

  always #50 clk = ~clk;

  gpio_pullup_opendrain_port dut_u (
    .i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_pad_in(level),
    .i_ext_reset_opt(ext_opt), .o_pad(pad)
  );

  board_model board_u (.i_clk(clk), .i_pad(pad), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(level));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Pin level seen by software: own latch on outputs, board level on inputs
  function logic [7:0] pin_mix(input logic [7:0] dir, input logic [7:0] latch, input logic [7:0] ext);
    return (latch & dir) | (ext & ~dir);
  endfunction

  task automatic complete_run();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single transfer; waits on hready with a bounded count
  task automatic bus(input logic wr_en, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rdata);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'b10;
    hwrite <= wr_en;
    do
    begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do
    begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 32);
    rdata = hrdata;
    chk(32'(hresp), 32'h0000_0000);
    if (hready !== 1'b1)
    begin
      fails++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, {22'h00_0000, idx, 2'b00}, 32'(d), r);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, {22'h00_0000, idx, 2'b00}, 32'h0000_0000, r);
    chk(r, 32'(e));
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial
  begin
    idle(10);
    rst <= 1'b0;
    chk(pad.oe, 16'h0000);
    chk(pad.out, 16'h0000);
    chk(pad.pu, 16'h8000);
    rd(`IDX_PORT_FIVE_DIR, 8'h40);
    wr(`IDX_PORT_FIVE_DIR, 8'hff);
    rd(`IDX_PORT_FIVE_DIR, 8'h7f);
    for (int k = 0; k < 8; k++)
    begin
      v = rnd();
      wr(`IDX_PORT_ONE_PULLUP, v[15:8]);
      wr(`IDX_PORT_ONE_DIR, v[7:0]);
      ext_en[8:1] <= ~v[7:0];
      ext_val[8:1] <= v[23:16];
      wr(`IDX_PORT_ONE_DATA, v[31:24]);
      idle(6);
      chk(pad.pu[8:1], v[15:8]);
      chk(pad.oe[8:1], v[7:0]);
      chk(pad.out[8:1] & v[7:0], v[31:24] & v[7:0]);
      rd(`IDX_PORT_ONE_DATA, pin_mix(v[7:0], v[31:24], v[23:16]));
      rd(`IDX_PORT_ONE_PULLUP, 8'h00);
    end
    wr(`IDX_PORT_FIVE_PULLUP, 8'h00);
    wr(`IDX_PORT_ZERO_PULLUP, 8'h01);
    idle(2);
    chk(pad.pu[15:9], 7'h40);
    chk(pad.pu[0], 1'b1);
    // Bit set and clear on a known pattern, all pins of ports zero and one outputs
    ext_en <= 16'h8000;
    wr(`IDX_PORT_ONE_DIR, 8'hff);
    wr(`IDX_PORT_ZERO_DIR, 8'h01);
    wr(`IDX_PORT_ONE_DATA, 8'h5a);
    wr(`IDX_PORT_ONE_SET, 8'h81);
    wr(`IDX_PORT_ZERO_SET, 8'h01);
    idle(2);
    chk(pad.out[8:0], 9'h1b7);
    wr(`IDX_PORT_ONE_CLR, 8'h42);
    wr(`IDX_PORT_ZERO_CLR, 8'h01);
    idle(2);
    chk(pad.out[8:0], 9'h132);
    // Input-only pin and the reset-pin option
    wr(`IDX_PORT_FIVE_DIR, 8'h3f);
    wr(`IDX_PORT_FIVE_DATA, 8'h7f);
    idle(6);
    chk(pad.oe[15:9], 7'h3f);
    rd(`IDX_PORT_FIVE_DATA, 8'h3f);
    ext_opt <= 1'b1;
    idle(4);
    rd(`IDX_PORT_FIVE_DATA, 8'h7f);
    ext_opt <= 1'b0;
    // Open-drain: outputs set first, control written as whole bytes
    wr(`IDX_PORT_FIVE_DATA, 8'h15);
    wr(`IDX_OPEN_DRAIN_CONTROL, 8'hff);
    idle(6);
    chk(pad.oe[14:9], 6'h2a);
    chk(pad.out[13:9] & pad.oe[13:9], 5'h00);
    rd(`IDX_PORT_FIVE_DATA, 8'h15);
    wr(`IDX_OPEN_DRAIN_CONTROL, 8'h04);
    idle(2);
    chk(pad.oe[14:9], 6'h3e);
    wr(`IDX_OPEN_DRAIN_CONTROL, 8'h00);
    idle(2);
    chk(pad.oe[14:9], 6'h3f);
    chk(pad.out[14:9], 6'h15);
    rd(`IDX_OPEN_DRAIN_CONTROL, 8'h00);
    // Unmapped and misaligned places read zero
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    bus(1'b0, {22'h00_0000, `IDX_PORT_ONE_DIR, 2'b01}, 32'h0000_0000, v);
    chk(v, 32'h0000_0000);
    // Second reset in mid-run
    rst <= 1'b1;
    idle(2);
    chk(pad.oe, 16'h0000);
    chk(pad.out, 16'h0000);
    chk(pad.pu, 16'h8000);
    rst <= 1'b0;
    ext_en <= '1;
    ext_val <= '0;
    rd(`IDX_PORT_ONE_DIR, 8'h00);
    complete_run();
  end
endmodule
